// ---- core/rcs_core.v ----
`timescale 1ns/1ps
`include "rcs_defs.vh"
module rcs_core
(
	input wire clk_i,
	input wire rst_i,
	input wire por_i,
	input wire brownout_i,
	input wire master_clear_pin_i,
	input wire watchdog_timer_timeout_i,
	input wire irq_wake_i,
	input wire sleep_i,
	input wire global_irq_enable_i,
	input wire acc_we_i,
	input wire [7:0] acc_wdata_i,
	input wire pc_step_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	output reg timeout_flag_o,
	output reg powerdown_flag_o,
	output reg [12:0] pc_o,
	output reg asleep_o
);
	// ****************************************
	// Event synchronisers
	// ****************************************
	// Sources are pin or foreign-domain levels; edges are taken after sync
	wire [4:0] ev_raw;
	wire [4:0] ev_s;
	reg [4:0] ev_d_reg;
	assign ev_raw = {irq_wake_i, watchdog_timer_timeout_i, master_clear_pin_i, brownout_i, por_i};
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi = gi + 1)
		begin : g_sync
			rcs_sync u_sync
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.d_i(ev_raw[gi]),
				.q_o(ev_s[gi])
			);
		end
	endgenerate
	// Every source idles low and the edge register resets low,
	// so no false event follows the release of reset
	wire [4:0] ev_rise;
	assign ev_rise = ev_s & ~ev_d_reg;
	// ****************************************
	// State
	// ****************************************
	reg [7:0] status_reg;
	reg [7:0] status_next;
	reg [7:0] pwr_reg;
	reg [7:0] pwr_next;
	reg [12:0] pc_next;
	reg [7:0] acc_reg;
	reg [7:0] acc_next;
	reg acc_valid_reg;
	reg acc_valid_next;
	reg [2:0] cause_reg;
	reg [2:0] cause_next;
	reg asleep_next;
	wire apb_wr;
	wire apb_rd;
	// A write lands only at the edge that completes the access phase
	assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
	assign apb_rd = psel_i & penable_i & ~pwrite_i;
	// ****************************************
	// Power-control value left by a reset
	// ****************************************
	// Pin, watchdog and brown-out resets clear the software watchdog
	// enable and restore the fast oscillator; cause bits ride through, except BOR, which a brown-out clears
	wire [7:0] pwr_rst;
	assign pwr_rst = (pwr_reg & `RCS_PW_RST_KEEP) | `RCS_PW_RST_SET;
	// ****************************************
	// Next state, priority POR > BOR > MASTER_CLEAR_PIN > WDT > IRQ
	// ****************************************
	always @*
	begin
		status_next = status_reg;
		pwr_next = pwr_reg;
		pc_next = pc_o;
		acc_next = acc_reg;
		acc_valid_next = acc_valid_reg;
		cause_next = cause_reg;
		asleep_next = asleep_o;
		// Software writes first, so a reset event in the same cycle wins
		if (apb_wr && paddr_i == `RCS_OFF_PWRCTL)
			pwr_next = pwdata_i[7:0] & `RCS_PW_MASK;
		if (apb_wr && paddr_i == `RCS_OFF_STATUS)
			status_next = {status_reg[7:5], status_reg[4:3], pwdata_i[2:0]};
		if (acc_we_i)
		begin
			acc_next = acc_wdata_i;
			acc_valid_next = 1'b1;
		end
		if (sleep_i && !asleep_o)
		begin
			asleep_next = 1'b1;
			pc_next = pc_o + 13'h0001;
		end
		else if (pc_step_i && !asleep_o)
			pc_next = pc_o + 13'h0001;
		if (ev_rise[0])
		begin
			status_next = {3'b000, 1'b1, 1'b1, status_reg[2:0]};
			pwr_next = `RCS_PW_POR_VAL;
			pc_next = `RCS_PC_RESET;
			acc_valid_next = 1'b0;
			cause_next = `RCS_C_POR;
			asleep_next = 1'b0;
		end
		else if (ev_rise[1])
		begin
			status_next = {3'b000, 1'b1, 1'b1, status_reg[2:0]};
			pwr_next = pwr_rst;
			pwr_next[`RCS_PW_BOR] = 1'b0;
			pc_next = `RCS_PC_RESET;
			acc_valid_next = 1'b0;
			cause_next = `RCS_C_BOR;
			asleep_next = 1'b0;
		end
		else if (ev_rise[2])
		begin
			pc_next = `RCS_PC_RESET;
			pwr_next = pwr_rst;
			if (asleep_o)
			begin
				status_next = {3'b000, 1'b1, 1'b0, status_reg[2:0]};
				cause_next = `RCS_C_MASTER_CLEAR_PIN_SLP;
			end
			else
			begin
				status_next = {3'b000, status_reg[4:0]};
				cause_next = `RCS_C_MASTER_CLEAR_PIN;
			end
			asleep_next = 1'b0;
		end
		else if (ev_rise[3])
		begin
			if (asleep_o)
			begin
				status_next = {status_reg[7:5], 1'b0, 1'b0, status_reg[2:0]};
				pc_next = pc_o;
				cause_next = `RCS_C_WDT_WAKE;
			end
			else
			begin
				status_next = {3'b000, 1'b0, 1'b1, status_reg[2:0]};
				pwr_next = pwr_rst;
				pc_next = `RCS_PC_RESET;
				cause_next = `RCS_C_WDT_RST;
			end
			asleep_next = 1'b0;
		end
		else if (ev_rise[4] && asleep_o)
		begin
			status_next = {status_reg[7:5], 1'b1, 1'b0, status_reg[2:0]};
			pc_next = global_irq_enable_i ? `RCS_PC_IRQ : pc_o;
			cause_next = `RCS_C_IRQ_WAKE;
			asleep_next = 1'b0;
		end
	end
	// ****************************************
	// Registers, all flags commit together
	// ****************************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ev_d_reg <= 5'h0;
			status_reg <= `RCS_ST_POR_VAL;
			pwr_reg <= `RCS_PW_POR_VAL;
			pc_o <= `RCS_PC_RESET;
			acc_reg <= 8'h00;
			acc_valid_reg <= 1'b0;
			cause_reg <= `RCS_C_NONE;
			asleep_o <= 1'b0;
		end
		else
		begin
			ev_d_reg <= ev_s;
			status_reg <= status_next;
			pwr_reg <= pwr_next;
			pc_o <= pc_next;
			acc_reg <= acc_next;
			acc_valid_reg <= acc_valid_next;
			cause_reg <= cause_next;
			asleep_o <= asleep_next;
		end
	end
	// ****************************************
	// Flag outputs, from the same next value as the status register
	// ****************************************
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timeout_flag_o <= 1'b1;
			powerdown_flag_o <= 1'b1;
		end
		else
		begin
			timeout_flag_o <= status_next[`RCS_ST_TO];
			powerdown_flag_o <= status_next[`RCS_ST_PD];
		end
	end
	// ****************************************
	// APB slave, zero wait states
	// ****************************************
	reg [31:0] rd_mux;
	reg rd_err;
	always @*
	begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		case (paddr_i)
			`RCS_OFF_STATUS: rd_mux = {24'h000000, status_reg};
			`RCS_OFF_PWRCTL: rd_mux = {24'h000000, pwr_reg & `RCS_PW_MASK};
			`RCS_OFF_PC: rd_mux = {19'h00000, pc_o};
			`RCS_OFF_ACC: rd_mux = {23'h0, acc_valid_reg, acc_reg};
			`RCS_OFF_CAUSE: rd_mux = {29'h0, cause_reg};
			default: rd_err = 1'b1;
		endcase
	end
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			// Answer registered so outputs come from flops; no wait state
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & rd_err;
			prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : 32'h00000000;
		end
	end
endmodule

// ---- shared/rcs_defs.vh ----
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH
// APB byte offsets
`define RCS_OFF_STATUS 12'h000
`define RCS_OFF_PWRCTL 12'h004
`define RCS_OFF_PC 12'h008
`define RCS_OFF_ACC 12'h00C
`define RCS_OFF_CAUSE 12'h010
// Status field positions
`define RCS_ST_PD 3
`define RCS_ST_TO 4
// Power-control field positions
`define RCS_PW_BOR 0
`define RCS_PW_POR 1
`define RCS_PW_OSCF 3
`define RCS_PW_WDTON 4
// Vectors and reset values
`define RCS_PC_RESET 13'h0000
`define RCS_PC_IRQ 13'h0004
`define RCS_ST_POR_VAL 8'h18
`define RCS_PW_POR_VAL 8'h09
`define RCS_PW_RST_SET 8'h08
`define RCS_PW_RST_KEEP 8'h03
`define RCS_ST_MASK 8'hFF
`define RCS_PW_MASK 8'h1B
// Cause codes
`define RCS_C_NONE 3'h0
`define RCS_C_POR 3'h1
`define RCS_C_BOR 3'h2
`define RCS_C_MASTER_CLEAR_PIN 3'h3
`define RCS_C_MASTER_CLEAR_PIN_SLP 3'h4
`define RCS_C_WDT_RST 3'h5
`define RCS_C_WDT_WAKE 3'h6
`define RCS_C_IRQ_WAKE 3'h7
`endif

// ---- core/rcs_sync.v ----
`timescale 1ns/1ps
// Two-flop synchroniser for one asynchronous event line
module rcs_sync
(
	input wire clk_i,
	input wire rst_i,
	input wire d_i,
	output reg q_o
);
	reg meta_reg;
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_reg <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end
endmodule

// ---- tb/rcs_core_monitor.sv ----
`timescale 1ns/1ps
module rcs_monitor
(
	input wire clk_i,
	input wire rst_i,
	input wire master_clear_pin_i,
	input wire watchdog_timer_timeout_i,
	input wire irq_wake_i,
	input wire global_irq_enable_i,
	input wire psel_i,
	input wire penable_i,
	input wire pready_o,
	input wire timeout_flag_o,
	input wire powerdown_flag_o,
	input wire [12:0] pc_o,
	input wire asleep_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_mrun; !asleep_o && $rose(master_clear_pin_i); endsequence
	sequence s_mslp; asleep_o && $rose(master_clear_pin_i); endsequence
	sequence s_wrun; !asleep_o && $rose(watchdog_timer_timeout_i); endsequence
	sequence s_wslp; asleep_o && $rose(watchdog_timer_timeout_i); endsequence
	sequence s_ivec; asleep_o && global_irq_enable_i && $rose(irq_wake_i); endsequence
	chk_rst_flags: assert property ($fell(rst_i) |-> timeout_flag_o && powerdown_flag_o)
		else $error("reset flags");
	chk_rdy_setup: assert property (s_setup |=> pready_o)
		else $error("no ready");
	chk_rdy_once: assert property (pready_o |=> !pready_o)
		else $error("ready held");
	chk_master_clear_pin_pc: assert property (s_mrun |-> ##[1:5] pc_o == 13'h0000)
		else $error("pin reset pc");
	chk_master_clear_pin_sleep: assert property (s_mslp |-> ##[1:5] timeout_flag_o && !powerdown_flag_o)
		else $error("pin reset asleep");
	chk_wdt_reset: assert property (s_wrun |-> ##[1:5] !timeout_flag_o && powerdown_flag_o)
		else $error("watchdog reset");
	chk_wdt_wake: assert property (s_wslp |-> ##[1:5] !timeout_flag_o && !powerdown_flag_o)
		else $error("watchdog wake");
	chk_irq_vector: assert property (s_ivec |-> ##[1:5] pc_o == 13'h0004)
		else $error("irq vector");
endmodule
bind rcs_core rcs_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
	.master_clear_pin_i(master_clear_pin_i), .watchdog_timer_timeout_i(watchdog_timer_timeout_i),
	.irq_wake_i(irq_wake_i), .global_irq_enable_i(global_irq_enable_i), .penable_i(penable_i),
	.pready_o(pready_o), .timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
	.pc_o(pc_o), .asleep_o(asleep_o));

// ---- tb/rcs_core_tb.sv ----
`timescale 1ns/1ps
`include "rcs_defs.vh"
module rcs_core_tb;
	reg clk_i = 1'h0, rst_i = 1'h1, global_irq_enable = 1'h0, awe = 1'h0, stp = 1'h0, slp = 1'h0;
	reg psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	reg [4:0] evs = 5'h00;
	reg [7:0] ad = 8'h00;
	reg [11:0] pa = 12'h000;
	reg [31:0] pwd = 32'h0, w;
	reg [31:0] q[$];
	wire [31:0] rd;
	wire rdy;
	integer n_fail = 0, cmp_count = 0, t = 0;
	always #2.5 clk_i = ~clk_i;
	rcs_core uut (.clk_i(clk_i), .rst_i(rst_i), .por_i(evs[0]), .brownout_i(evs[1]),
		.master_clear_pin_i(evs[2]), .watchdog_timer_timeout_i(evs[3]), .irq_wake_i(evs[4]),
		.sleep_i(slp), .global_irq_enable_i(global_irq_enable), .acc_we_i(awe), .acc_wdata_i(ad),
		.pc_step_i(stp), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
		.pwdata_i(pwd), .prdata_o(rd), .pready_o(rdy), .pslverr_o(), .timeout_flag_o(),
		.powerdown_flag_o(), .pc_o(), .asleep_o());
	task chk(input [31:0] s, input [31:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (s !== e)
		begin
			n_fail = n_fail + 1;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	end
	endtask
	task final_report;
	begin
		$display("%0d compares, %0d mismatches", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task apb(input wr, input [11:0] a, input [31:0] d, input [31:0] e);
	begin
		if (!wr)
			q.push_back(e);
		psel <= 1'h1;
		pwr <= wr;
		pa <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1'h1;
		@(posedge clk_i);
		while (rdy !== 1'h1)
			@(posedge clk_i);
		psel <= 1'h0;
		pen <= 1'h0;
		@(posedge clk_i);
	end
	endtask
	task chkst(input [12:0] p, input [7:0] s, input [31:0] x);
	begin
		apb(1'h0, `RCS_OFF_PC, 32'h0, {19'h0, p});
		apb(1'h0, `RCS_OFF_STATUS, 32'h0, {24'h0, s});
		apb(1'h0, `RCS_OFF_PWRCTL, 32'h0, x);
		t = t + 1;
		$display("test %0d done", t);
	end
	endtask
	task ev(input [2:0] k, input s);
	begin
		slp <= s;
		@(posedge clk_i);
		slp <= 1'h0;
		evs[k] <= 1'h1;
		repeat (4) @(posedge clk_i);
		evs <= 5'h00;
		repeat (4) @(posedge clk_i);
	end
	endtask
	// Read data is judged against the oldest note
	always @(posedge clk_i)
		if (psel && pen && rdy === 1'h1 && !pwr)
			chk(rd, q.pop_front());
	initial
	begin
		#20000;
		n_fail = n_fail + 1;
		final_report;
	end
	initial
	begin
		w = $urandom(32'hFA99);
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		chkst(`RCS_PC_RESET, `RCS_ST_POR_VAL, `RCS_PW_POR_VAL);
		w = $urandom | 32'h3;
		ad <= w[15:8];
		apb(1'h1, `RCS_OFF_PWRCTL, w, 32'h0);
		apb(1'h1, 12'h020, w, 32'h0);
		w = w & `RCS_PW_MASK;
		awe <= 1'h1;
		stp <= 1'h1;
		repeat (3) @(posedge clk_i);
		awe <= 1'h0;
		stp <= 1'h0;
		chkst(13'h0003, 8'h18, w);
		w = (w & 32'h3) | 32'h8;
		ev(3'h2, 1'h0);
		chkst(`RCS_PC_RESET, 8'h18, w);
		ev(3'h2, 1'h1);
		chkst(`RCS_PC_RESET, 8'h10, w);
		ev(3'h3, 1'h1);
		chkst(13'h0001, 8'h00, w);
		ev(3'h3, 1'h0);
		chkst(`RCS_PC_RESET, 8'h08, w);
		ev(3'h4, 1'h1);
		chkst(13'h0001, 8'h10, w);
		global_irq_enable <= 1'h1;
		ev(3'h4, 1'h1);
		chkst(`RCS_PC_IRQ, 8'h10, w);
		apb(1'h0, `RCS_OFF_ACC, 32'h0, {23'h0, 1'h1, ad});
		ev(3'h1, 1'h0);
		chkst(`RCS_PC_RESET, 8'h18, w & 32'h1A);
		apb(1'h0, `RCS_OFF_ACC, 32'h0, {23'h0, 1'h0, ad});
		ev(3'h0, 1'h0);
		chkst(`RCS_PC_RESET, 8'h18, {24'h0, `RCS_PW_POR_VAL});
		final_report;
	end
endmodule
